/* psm_pkg.sv */
// Function
// - segment address pins switch to address output automatically after reset.
// - segment line count is strapped from low data port on the first clock after reset release, readable.
// - selection 01 none, 11 gives A16-A17, 00 gives A16-A19.
// - selection 10 drives A16-A23 on lines 0-7; two-wire wins lines 4, 7.
// - selection 10 gives no port line to either CAN controller.
// - two-wire enabled makes lines 4 and 7 clock and data only.
// - selection 10 with two-wire keeps A21, A22 on lines 5 and 6.
// - selection 10 masks second CAN on lines 4 and 7.
// - two-wire lines 4 and 7 are open-drain, both input and output.
// - selection 10 masks first CAN on lines 5 and 6.
// - parallel mode moves second CAN to lines 5, 6 only if first enabled.
// - CAN takes 2 or 4 lines that segment lines leave free; two-wire takes 2, reducing segment lines.
// - lines without segment address, CAN or two-wire stay general purpose I/O.
// - analog port is 16-bit input only, reads return pin states.
// - writes to analog port data register are discarded.
// - all 16 analog port lines feed converter channels 0-15 unconditionally.
// - analog port lines 10-15 feed timer direction and count inputs.
// - with two-wire on, port registers for lines 4 and 7 have no effect.
package psm_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [15:0] ANALOG_PORT_ADDR = 16'hffa2;
  localparam logic [15:0] MUX_CONTROL_ADDR = 16'hff10;
  localparam logic [15:0] RESET_CONFIG_ADDR = 16'hff12;
  localparam logic [4:0] MUX_CONTROL_RESET = 5'h00;

  // ----------------------------------------------------------------
  // segment line selection
  // ----------------------------------------------------------------
  localparam int SEL_STRAP_LSB = 9;
  localparam logic [1:0] SEL_NONE = 2'h1;
  localparam logic [1:0] SEL_TWO = 2'h3;
  localparam logic [1:0] SEL_FOUR = 2'h0;
  localparam logic [1:0] SEL_EIGHT = 2'h2;
  localparam logic [1:0] SEL_RESET = 2'h1;
  localparam logic [7:0] SEG_MASK_NONE = 8'h00;
  localparam logic [7:0] SEG_MASK_TWO = 8'h03;
  localparam logic [7:0] SEG_MASK_FOUR = 8'h0f;
  localparam logic [7:0] SEG_MASK_EIGHT = 8'hff;

  // ----------------------------------------------------------------
  // line positions on the 8-bit port
  // ----------------------------------------------------------------
  localparam int LINE_SCL = 4;
  localparam int LINE_CAN1_RX = 5;
  localparam int LINE_CAN1_TX = 6;
  localparam int LINE_SDA = 7;

  // ----------------------------------------------------------------
  // timer input lines on the analog port
  // ----------------------------------------------------------------
  localparam int LINE_T6_DIR = 10;
  localparam int LINE_T5_DIR = 11;
  localparam int LINE_T6_CNT = 12;
  localparam int LINE_T5_CNT = 13;
  localparam int LINE_T4_DIR = 14;
  localparam int LINE_T2_DIR = 15;

  // mux control register, bit 4 downward
  typedef struct packed {
    logic can_parallel;
    logic second_can_enable;
    logic first_can_enable;
    logic two_wire_enable;
    logic peripheral_bus_enable;
  } psm_ctrl_t;

  typedef struct packed {
    logic timer2_direction_input;
    logic timer4_direction_input;
    logic timer5_count_input;
    logic timer6_count_input;
    logic timer5_direction_input;
    logic timer6_direction_input;
  } psm_timer_in_t;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] dir;
    logic [7:0] open_drain;
  } psm_gpio_cfg_t;

endpackage

/* psm_pin_mux.sv */
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module psm_pin_mux
  import psm_pkg::*;
#(
  parameter int ANALOG_WIDTH = 16
)
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic [15:0] i_low_data_port,
  input wire psm_gpio_cfg_t i_gpio_cfg,
  input wire logic [7:0] i_seg_addr,
  input wire logic i_first_can_transmit,
  input wire logic i_second_can_transmit,
  input wire logic i_scl_drive,
  input wire logic i_sda_drive,
  input wire logic [7:0] i_port4_pin_in,
  output logic [7:0] o_port4_pin_out,
  output logic [7:0] o_port4_pin_oe_n,
  output logic [7:0] o_port4_levels,
  output logic o_first_can_receive,
  output logic o_second_can_receive,
  output logic o_scl_in,
  output logic o_sda_in,
  input wire logic [ANALOG_WIDTH-1:0] i_analog_pins,
  output logic [ANALOG_WIDTH-1:0] o_analog_channel_inputs,
  output psm_timer_in_t o_timer_inputs
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  function automatic logic [7:0] seg_mask(input logic [1:0] sel);
    logic [7:0] m;
    m = SEG_MASK_NONE;
    unique case (sel)
      SEL_NONE: m = SEG_MASK_NONE;
      SEL_TWO: m = SEG_MASK_TWO;
      SEL_FOUR: m = SEG_MASK_FOUR;
      SEL_EIGHT: m = SEG_MASK_EIGHT;
    endcase
    return m;
  endfunction

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  // the strap is taken on the first clock after release, never under reset
  logic [1:0] segment_line_select;
  logic strap_taken;

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      segment_line_select <= SEL_RESET;
      strap_taken <= 1'b0;
    end
    else if (!strap_taken)
    begin
      segment_line_select <= i_low_data_port[SEL_STRAP_LSB +: 2];
      strap_taken <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  psm_ctrl_t mux_control;
  logic [ANALOG_WIDTH-1:0] analog_port_pin_levels;

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      mux_control <= MUX_CONTROL_RESET;
    else if (i_wr && i_addr == MUX_CONTROL_ADDR)
      mux_control <= i_wdata[4:0];
  end

  // the analog port has no latch: writes to its address fall through
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      analog_port_pin_levels <= '0;
    else
      analog_port_pin_levels <= i_analog_pins;
  end

  logic [15:0] next_rdata;

  always_comb
  begin
    next_rdata = 16'h0000;
    if (i_rd)
    begin
      unique case (i_addr)
        ANALOG_PORT_ADDR: next_rdata = 16'(analog_port_pin_levels);
        MUX_CONTROL_ADDR: next_rdata = {11'h000, mux_control};
        RESET_CONFIG_ADDR: next_rdata = {14'h0000, segment_line_select};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      o_rdata <= 16'h0000;
    else
      o_rdata <= next_rdata;
  end

  // ----------------------------------------------------------------
  // 8-bit port arbitration
  // ----------------------------------------------------------------
  logic two_wire_on;
  logic [7:0] seg_lines;
  logic can_allowed;
  logic can1_on;
  logic can2_on;
  logic can2_remap;

  assign two_wire_on = mux_control.peripheral_bus_enable & mux_control.two_wire_enable;
  assign seg_lines = seg_mask(segment_line_select);
  // external memory outranks both controllers
  assign can_allowed = (segment_line_select != SEL_EIGHT);
  assign can1_on = mux_control.first_can_enable & can_allowed;
  assign can2_on = mux_control.second_can_enable & can_allowed;
  assign can2_remap = mux_control.can_parallel & can1_on;

  logic [7:0] next_pin_out;
  logic [7:0] next_pin_oe_n;

  always_comb
  begin
    next_pin_out = 8'hff;
    next_pin_oe_n = 8'hff;
    for (int l = 0; l < 8; l++)
    begin
      if (two_wire_on && (l == LINE_SCL || l == LINE_SDA))
      begin
        // open-drain: only a low is driven, port registers are bypassed
        next_pin_out[l] = 1'b0;
        next_pin_oe_n[l] = (l == LINE_SCL) ? i_scl_drive : i_sda_drive;
      end
      else if (seg_lines[l])
      begin
        next_pin_out[l] = i_seg_addr[l];
        next_pin_oe_n[l] = 1'b0;
      end
      else if (l == LINE_CAN1_TX && can1_on)
      begin
        // in parallel mode both transmitters share the bus, dominant low wins
        next_pin_out[l] = i_first_can_transmit & (~(can2_remap & can2_on)
                          | i_second_can_transmit);
        next_pin_oe_n[l] = 1'b0;
      end
      else if (l == LINE_SDA && can2_on && !can2_remap)
      begin
        next_pin_out[l] = i_second_can_transmit;
        next_pin_oe_n[l] = 1'b0;
      end
      else if ((l == LINE_CAN1_RX && can1_on) ||
               (l == LINE_SCL && can2_on && !can2_remap))
      begin
        next_pin_out[l] = 1'b1;
        next_pin_oe_n[l] = 1'b1;
      end
      else if (i_gpio_cfg.dir[l])
      begin
        next_pin_out[l] = i_gpio_cfg.data[l];
        next_pin_oe_n[l] = i_gpio_cfg.open_drain[l] & i_gpio_cfg.data[l];
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_port4_pin_out <= 8'hff;
      o_port4_pin_oe_n <= 8'hff;
    end
    else
    begin
      o_port4_pin_out <= next_pin_out;
      o_port4_pin_oe_n <= next_pin_oe_n;
    end
  end

  // ----------------------------------------------------------------
  // receive paths
  // ----------------------------------------------------------------
  // an unowned receiver sees recessive high so it never reads a stray bit
  logic next_can1_rx;
  logic next_can2_rx;

  always_comb
  begin
    next_can1_rx = can1_on ? i_port4_pin_in[LINE_CAN1_RX] : 1'b1;
    next_can2_rx = 1'b1;
    if (can2_on && can2_remap)
      next_can2_rx = i_port4_pin_in[LINE_CAN1_RX];
    else if (can2_on && !two_wire_on)
      next_can2_rx = i_port4_pin_in[LINE_SCL];
  end

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_first_can_receive <= 1'b1;
      o_second_can_receive <= 1'b1;
      o_scl_in <= 1'b1;
      o_sda_in <= 1'b1;
      o_port4_levels <= 8'h00;
    end
    else
    begin
      o_first_can_receive <= next_can1_rx;
      o_second_can_receive <= next_can2_rx;
      o_scl_in <= two_wire_on ? i_port4_pin_in[LINE_SCL] : 1'b1;
      o_sda_in <= two_wire_on ? i_port4_pin_in[LINE_SDA] : 1'b1;
      o_port4_levels <= i_port4_pin_in;
    end
  end

  // ----------------------------------------------------------------
  // analog port fan-out
  // ----------------------------------------------------------------
  // the converter sees a digital copy here; the analog path is at the pads
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_analog_channel_inputs <= '0;
      o_timer_inputs <= '0;
    end
    else
    begin
      o_analog_channel_inputs <= analog_port_pin_levels;
      o_timer_inputs.timer6_direction_input <= analog_port_pin_levels[LINE_T6_DIR];
      o_timer_inputs.timer5_direction_input <= analog_port_pin_levels[LINE_T5_DIR];
      o_timer_inputs.timer6_count_input <= analog_port_pin_levels[LINE_T6_CNT];
      o_timer_inputs.timer5_count_input <= analog_port_pin_levels[LINE_T5_CNT];
      o_timer_inputs.timer4_direction_input <= analog_port_pin_levels[LINE_T4_DIR];
      o_timer_inputs.timer2_direction_input <= analog_port_pin_levels[LINE_T2_DIR];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_eight_lines;
    strap_taken && segment_line_select == SEL_EIGHT;
  endsequence

  sequence s_two_wire_on;
    mux_control.peripheral_bus_enable && mux_control.two_wire_enable;
  endsequence

  a_strap_capture: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    $rose(strap_taken) |-> segment_line_select == $past(i_low_data_port[10:9]))
    else $error("segment selection not taken from strap");

  a_four_line_addr: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (strap_taken && segment_line_select == SEL_FOUR) |=>
      (o_port4_pin_oe_n[3:0] == 4'h0 && o_port4_pin_out[3:0] == $past(i_seg_addr[3:0])))
    else $error("segment lines 0-3 not driven");

  a_none_is_gpio: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (strap_taken && segment_line_select == SEL_NONE && i_gpio_cfg.dir[0]
      && !i_gpio_cfg.open_drain[0]) |=>
      (!o_port4_pin_oe_n[0] && o_port4_pin_out[0] == $past(i_gpio_cfg.data[0])))
    else $error("line 0 not general purpose");

  a_eight_line_addr: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (s_eight_lines and !two_wire_on) |=>
      (o_port4_pin_oe_n == 8'h00 && o_port4_pin_out == $past(i_seg_addr)))
    else $error("address lines 16-23 not driven");

  a_can_blocked: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    s_eight_lines |=> (o_first_can_receive && o_second_can_receive))
    else $error("CAN receiver reached the port under eight lines");

  a_two_wire_low: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (s_two_wire_on and !i_scl_drive) |=> (!o_port4_pin_oe_n[4] && !o_port4_pin_out[4]))
    else $error("clock line not pulled low");

  a_two_wire_float: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (s_two_wire_on and i_sda_drive) |=> o_port4_pin_oe_n[7] [*1] ##1 1'b1)
    else $error("data line driven while released");

  a_keep_mid_addr: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (s_eight_lines and s_two_wire_on) |=>
      (o_port4_pin_oe_n[6:5] == 2'h0 && o_port4_pin_out[6:5] == $past(i_seg_addr[6:5])))
    else $error("address lines 21-22 lost under two-wire");

  a_can2_remap: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (can2_remap && can2_on) |=> o_second_can_receive == $past(i_port4_pin_in[5]))
    else $error("second CAN receive not remapped");

  a_analog_read: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (i_rd && i_addr == ANALOG_PORT_ADDR && $past(rst_n)) |=>
      o_rdata == $past(i_analog_pins, 2))
    else $error("analog port read does not return pins");

  a_timer_map: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    ($past(rst_n) && $past(rst_n, 2)) |->
      (o_timer_inputs.timer2_direction_input == $past(i_analog_pins[15], 2)
       && o_analog_channel_inputs == $past(i_analog_pins, 2)))
    else $error("analog lines not fanned out");

  // the remapped transmitter must reach the shared line, dominant low winning
  a_parallel_tx: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (can2_remap && can2_on && !i_second_can_transmit) |=>
      (!o_port4_pin_oe_n[6] && !o_port4_pin_out[6]))
    else $error("second CAN transmit not on shared line");

  a_sda_sampled: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    s_two_wire_on |=> o_sda_in == $past(i_port4_pin_in[LINE_SDA]))
    else $error("data line level not returned");

  a_pad_levels: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    $past(rst_n) |-> o_port4_levels == $past(i_port4_pin_in))
    else $error("port levels not copied");

endmodule

/* psm_far_side.sv */
`timescale 1ns/1ps
module psm_far_side
(
  input wire logic [7:0] i_pin_out,
  input wire logic [7:0] i_pin_oe_n,
  input wire logic [7:0] i_pull_low,
  output logic [7:0] o_pin_level
);
  // ----------------------------------------------------------------
  // wired pads
  // ----------------------------------------------------------------
  // each pad has a board pull-up, so a released pad reads 1 and never a stale
  // value; transceivers and two-wire devices can only pull a pad low
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      o_pin_level[i] = ~i_pull_low[i] & (i_pin_oe_n[i] | i_pin_out[i]);
    end
  end
endmodule

/* test_port_segment_can_i2c_pin_mux.sv */
`timescale 1ns/1ps
module test_port_segment_can_i2c_pin_mux;
  import psm_pkg::*;
  logic clk;
  logic reset_n;
  logic [15:0] addr, wdata, rdata, low_port, apins, achan;
  logic wr, rd, tx1, tx2, scl_drv, sda_drv, rx1, rx2, scl_in, sda_in;
  logic [7:0] seg, pin_out, oe_n, levels, pin_level, pull_low;
  psm_gpio_cfg_t cfg;
  psm_timer_in_t tmr;
  int fails, checked, cycles;

  psm_pin_mux dut_u (.i_clk_sys(clk), .i_reset_n(reset_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_low_data_port(low_port), .i_gpio_cfg(cfg),
    .i_seg_addr(seg), .i_first_can_transmit(tx1), .i_second_can_transmit(tx2),
    .i_scl_drive(scl_drv), .i_sda_drive(sda_drv), .i_port4_pin_in(pin_level),
    .o_port4_pin_out(pin_out), .o_port4_pin_oe_n(oe_n), .o_port4_levels(levels),
    .o_first_can_receive(rx1), .o_second_can_receive(rx2), .o_scl_in(scl_in),
    .o_sda_in(sda_in), .i_analog_pins(apins), .o_analog_channel_inputs(achan),
    .o_timer_inputs(tmr));
  psm_far_side far_u (.i_pin_out(pin_out), .i_pin_oe_n(oe_n), .i_pull_low(pull_low),
    .o_pin_level(pin_level));

  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      report_and_stop;
    end
  end

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // pins follow config one cycle late, control writes two; three leaves margin
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task rd_chk(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // strap must stay put until the selection is captured after release
  task do_reset(input logic [1:0] sel);
    @(posedge clk);
    reset_n <= 1'b0;
    low_port <= {5'h00, sel, 9'h000};
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_strap;
    logic [1:0] sel [4];
    logic [7:0] m [4];
    logic [7:0] eo;
    sel = '{SEL_NONE, SEL_TWO, SEL_FOUR, SEL_EIGHT};
    m = '{SEG_MASK_NONE, SEG_MASK_TWO, SEG_MASK_FOUR, SEG_MASK_EIGHT};
    for (int k = 0; k < 4; k++)
    begin
      do_reset(sel[k]);
      rd_chk(RESET_CONFIG_ADDR, {14'h0000, sel[k]});
      rd_chk(MUX_CONTROL_ADDR, 16'h0000);
      eo = 8'h50 & ~m[k];
      chk(16'(oe_n), 16'(eo));
      chk(16'(pin_out | oe_n), 16'((seg & m[k]) | (8'h5a & ~m[k]) | eo));
    end
    $display("strap selection test done");
  endtask

  task t_eight;
    @(posedge clk);
    scl_drv <= 1'b0;
    sda_drv <= 1'b1;
    wr_reg(MUX_CONTROL_ADDR, 16'h000f);
    settle;
    chk(16'(oe_n), 16'h0080);
    chk(16'(pin_out & 8'h7f), 16'(seg & 8'h6f));
    chk({14'h0000, scl_in, sda_in}, 16'h0001);
    @(posedge clk);
    scl_drv <= 1'b1;
    pull_low <= 8'h10;
    settle;
    chk({oe_n[4], 14'h0000, scl_in}, 16'h8000);
    @(posedge clk);
    pull_low <= 8'h00;
    wr_reg(MUX_CONTROL_ADDR, 16'h000d);
    settle;
    chk(16'(oe_n), 16'h0000);
    chk(16'(pin_out), 16'(seg));
    chk({14'h0000, rx1, rx2}, 16'h0003);
    $display("eight line priority test done");
  endtask

  task t_can;
    do_reset(SEL_NONE);
    @(posedge clk);
    tx1 <= 1'b0;
    tx2 <= 1'b0;
    pull_low <= 8'h20;
    wr_reg(MUX_CONTROL_ADDR, 16'h000c);
    settle;
    chk(16'(oe_n), 16'h0030);
    chk(16'(pin_out & 8'hcf), 16'h000a);
    chk({14'h0000, rx1, rx2}, 16'h0001);
    @(posedge clk);
    tx1 <= 1'b1;
    wr_reg(MUX_CONTROL_ADDR, 16'h001c);
    settle;
    chk(16'(oe_n), 16'h0030);
    chk(16'(pin_out & 8'hcf), 16'h000a);
    chk({14'h0000, rx1, rx2}, 16'h0000);
    wr_reg(MUX_CONTROL_ADDR, 16'h0018);
    settle;
    chk(16'(oe_n), 16'h0050);
    chk(16'(pin_out & 8'haf), 16'h000a);
    chk({14'h0000, rx1, rx2}, 16'h0003);
    @(posedge clk);
    scl_drv <= 1'b1;
    sda_drv <= 1'b1;
    pull_low <= 8'h80;
    wr_reg(MUX_CONTROL_ADDR, 16'h0003);
    settle;
    chk(16'(oe_n), 16'h00d0);
    chk({14'h0000, scl_in, sda_in}, 16'h0002);
    chk(16'(levels), 16'h005a);
    $display("can mapping test done");
  endtask

  task t_analog;
    @(posedge clk);
    apins <= 16'ha53c;
    settle;
    chk(achan, 16'ha53c);
    chk(16'(tmr), 16'h0029);
    rd_chk(ANALOG_PORT_ADDR, 16'ha53c);
    wr_reg(ANALOG_PORT_ADDR, 16'h1234);
    wr_reg(RESET_CONFIG_ADDR, 16'h0003);
    rd_chk(ANALOG_PORT_ADDR, 16'ha53c);
    @(posedge clk);
    apins <= 16'h5ac3;
    settle;
    rd_chk(ANALOG_PORT_ADDR, 16'h5ac3);
    rd_chk(RESET_CONFIG_ADDR, {14'h0000, SEL_NONE});
    wr_reg(MUX_CONTROL_ADDR, 16'hffff);
    rd_chk(MUX_CONTROL_ADDR, 16'h001f);
    @(posedge clk);
    #1;
    chk(rdata, 16'h0000);
    rd_chk(16'hff00, 16'h0000);
    $display("analog port and register test done");
  endtask

  initial
  begin
    clk = 1'b0;
    reset_n = 1'b0;
    addr = 16'h0000;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    low_port = 16'h0000;
    cfg = '{data: 8'h5a, dir: 8'hff, open_drain: 8'hf0};
    seg = 8'h96;
    tx1 = 1'b1;
    tx2 = 1'b1;
    scl_drv = 1'b1;
    sda_drv = 1'b1;
    pull_low = 8'h00;
    apins = 16'h0000;
    fails = 0;
    checked = 0;
    cycles = 0;
    t_strap;
    t_eight;
    t_can;
    t_analog;
    report_and_stop;
  end
endmodule
